// ===== design/port_router_defs.svh
// Constants for the port function router: register map, fields, codes.
// Assumes a 12-bit APB byte address and four port groups of eight pins.
`ifndef PORT_ROUTER_DEFS_SVH
`define PORT_ROUTER_DEFS_SVH

// Register map (byte addresses)
`define RTR_ADDR_W          12
`define RTR_ROUTE_BASE      12'h000
`define RTR_ROUTE_MASK      12'h03C
`define RTR_FNC_BASE        12'h040
`define RTR_DIR_BASE        12'h050
`define RTR_MODE_BASE       12'h060
`define RTR_STAT_BASE       12'h070
`define RTR_BLOCK_MASK      12'hFF0
`define RTR_ROUTE_BLK_MASK  12'hFC0
`define RTR_ALIGN_MASK      12'h003
`define RTR_MAP_TOP_MASK    12'hF80
`define RTR_REG_RESET       16'h0000
`define RTR_ROUTE_IDX       5:2
`define RTR_GROUP_IDX       3:2

// Route setting fields, even pin then odd pin
`define RTR_EVEN_PER        2:0
`define RTR_EVEN_CH         4:3
`define RTR_EVEN_SIG        7:5
`define RTR_ODD_PER         10:8
`define RTR_ODD_CH          12:11
`define RTR_ODD_SIG         15:13

// Function choice selecting the routed function
`define RTR_FNC_PERIPH1     2'h1

// Peripheral codes
`define RTR_PER_NONE        3'h0
`define RTR_PER_I2C         3'h1
`define RTR_PER_SPI         3'h2
`define RTR_PER_UART        3'h3
`define RTR_PER_TMR         3'h4

// Highest legal channel per peripheral
`define RTR_I2C_CH_MAX      2'h0
`define RTR_SPI_CH_MAX      2'h1
`define RTR_UART_CH_MAX     2'h1
`define RTR_TMR_CH_MAX      2'h2

// Signal codes
`define RTR_SIG_1           3'h1
`define RTR_SIG_2           3'h2
`define RTR_SIG_3           3'h3
`define RTR_SIG_4           3'h4

// Peripheral line numbering
`define RTR_NUM_LINES       20
`define RTR_LINE_I2C        5'h00
`define RTR_LINE_SPI        5'h02
`define RTR_LINE_UART       5'h0A
`define RTR_LINE_TMR        5'h0E
`define RTR_LINE_SPI1_SS    5'h09
`define RTR_LINE_I2C_SDA    5'h01
`define RTR_LINE_UART1_TX   5'h0D
`define RTR_LINE_TMR2_OUT1  5'h13
`define RTR_LINE_INPUT_ONLY 20'h01444
`define RTR_LINE_IDLE       20'h01623

`endif

// ===== design/port_router_pkg.sv
// Types shared by the port function router files.
// Assumes port_router_defs.svh is on the include path.
`include "port_router_defs.svh"

package port_router_pkg;
    typedef logic [15:0] reg16_type;
    typedef logic [4:0]  line_type;
    typedef enum logic [2:0] {
        PER_NONE = `RTR_PER_NONE,
        PER_I2C  = `RTR_PER_I2C,
        PER_SPI  = `RTR_PER_SPI,
        PER_UART = `RTR_PER_UART,
        PER_TMR  = `RTR_PER_TMR
    } periph_type;
endpackage

// ===== design/route_decoder.sv
// One pin's route decode: peripheral, channel, signal to a line number.
// Purely combinational; the caller registers what it drives.
`timescale 1ns/1ps

module route_decoder
    import port_router_pkg::*;
(
    // Route setting fields
    input  wire logic [2:0] perChoice,
    input  wire logic [1:0] chChoice,
    input  wire logic [2:0] sigChoice,
    // Decode result
    output logic            lineValid,
    output line_type        lineNum
);
    wire logic [2:0] sigLess1 = sigChoice - `RTR_SIG_1;
    wire logic       sig12    = (sigChoice == `RTR_SIG_1) || (sigChoice == `RTR_SIG_2);
    wire logic       sig1to4  = sig12 || (sigChoice == `RTR_SIG_3) || (sigChoice == `RTR_SIG_4);

    wire logic i2cOk  = (perChoice == `RTR_PER_I2C)  && (chChoice <= `RTR_I2C_CH_MAX)  && sig12;
    wire logic spiOk  = (perChoice == `RTR_PER_SPI)  && (chChoice <= `RTR_SPI_CH_MAX)  && sig1to4;
    wire logic uartOk = (perChoice == `RTR_PER_UART) && (chChoice <= `RTR_UART_CH_MAX) && sig12;
    wire logic tmrOk  = (perChoice == `RTR_PER_TMR)  && (chChoice <= `RTR_TMR_CH_MAX)  && sig12;

    // Reserved peripheral, channel or signal codes leave the pin unassigned
    assign lineValid = i2cOk || spiOk || uartOk || tmrOk;

    // Lines are packed per channel, signal order as coded
    assign lineNum = i2cOk  ? `RTR_LINE_I2C  + line_type'(sigLess1[0])
                   : spiOk  ? `RTR_LINE_SPI  + line_type'({chChoice[0], sigLess1[1:0]})
                   : uartOk ? `RTR_LINE_UART + line_type'({chChoice[0], sigLess1[0]})
                   : tmrOk  ? `RTR_LINE_TMR  + line_type'({chChoice, sigLess1[0]})
                   : `RTR_LINE_I2C;
endmodule // route_decoder

// ===== design/port_function_router.sv
// Port function router: routes one peripheral line to each port pin.
// Assumes an APB master on core_clk and port logic supplying GPIO drive.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps

module port_function_router
    import port_router_pkg::*;
#(
    parameter int NUM_GROUPS     = 4,
    parameter int PINS_PER_GROUP = 8
) (
    // Clock and reset
    input  wire logic                               core_clk,
    input  wire logic                               srst,
    // APB slave
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [`RTR_ADDR_W-1:0]             paddr,
    input  wire logic [31:0]                        pwdata,
    output logic      [31:0]                        prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    // Port pads
    input  wire logic [NUM_GROUPS*PINS_PER_GROUP-1:0] padIn,
    output logic      [NUM_GROUPS*PINS_PER_GROUP-1:0] padOut,
    output logic      [NUM_GROUPS*PINS_PER_GROUP-1:0] padOe,
    // GPIO drive from port logic
    input  wire logic [NUM_GROUPS*PINS_PER_GROUP-1:0] gpioOut,
    input  wire logic [NUM_GROUPS*PINS_PER_GROUP-1:0] gpioOe,
    // Peripheral lines
    input  wire logic [`RTR_NUM_LINES-1:0]          periphOut,
    input  wire logic [`RTR_NUM_LINES-1:0]          periphOe,
    output logic      [`RTR_NUM_LINES-1:0]          periphIn
);
    localparam int NUM_PINS   = NUM_GROUPS * PINS_PER_GROUP;
    localparam int NUM_ROUTES = NUM_GROUPS * PINS_PER_GROUP / 2;

    // Register state
    reg16_type routeSet_q [NUM_ROUTES];
    reg16_type fncSel_q   [NUM_GROUPS];
    reg16_type dirEn_q    [NUM_GROUPS];
    logic [PINS_PER_GROUP-1:0] mode_q [NUM_GROUPS];

    logic [31:0]           prdata_q;
    logic                  pready_q;
    logic                  pslverr_q;
    logic [NUM_PINS-1:0]   padOut_q;
    logic [NUM_PINS-1:0]   padOe_q;
    logic [NUM_PINS-1:0]   padOut_d;
    logic [NUM_PINS-1:0]   padOe_d;
    logic [`RTR_NUM_LINES-1:0] periphIn_q;
    logic [`RTR_NUM_LINES-1:0] periphIn_d;

    // Per pin decode
    logic [2:0]          pinPer   [NUM_PINS];
    logic [1:0]          pinCh    [NUM_PINS];
    logic [2:0]          pinSig   [NUM_PINS];
    line_type            pinLine  [NUM_PINS];
    logic [NUM_PINS-1:0] pinValid;
    logic [NUM_PINS-1:0] pinRouted;
    logic [NUM_PINS-1:0] pinActive;
    logic [NUM_PINS-1:0] pinSelOut;
    logic [NUM_PINS-1:0] pinSelOe;

    wire logic [`RTR_NUM_LINES-1:0] inputOnly = `RTR_LINE_INPUT_ONLY;
    wire logic [`RTR_NUM_LINES-1:0] lineIdle  = `RTR_LINE_IDLE;

    // APB decode
    wire logic                    setupPhase = psel && !penable;
    wire logic                    accessDone = psel && penable && pready_q;
    wire logic [`RTR_ADDR_W-1:0]  blockAddr  = paddr & `RTR_BLOCK_MASK;
    wire logic [`RTR_ADDR_W-1:0]  routeBlk   = paddr & `RTR_ROUTE_BLK_MASK;
    wire logic                    aligned    = (paddr & `RTR_ALIGN_MASK) == 12'h000;
    wire logic                    hitRoute   = aligned && (routeBlk == `RTR_ROUTE_BASE);
    wire logic                    hitFnc     = aligned && (blockAddr == `RTR_FNC_BASE);
    wire logic                    hitDir     = aligned && (blockAddr == `RTR_DIR_BASE);
    wire logic                    hitMode    = aligned && (blockAddr == `RTR_MODE_BASE);
    wire logic                    hitStat    = aligned && (blockAddr == `RTR_STAT_BASE);
    wire logic                    mapped     = hitRoute || hitFnc || hitDir || hitMode || hitStat;
    wire logic [3:0]              routeIdx   = paddr[`RTR_ROUTE_IDX];
    wire logic [1:0]              groupIdx   = paddr[`RTR_GROUP_IDX];
    wire reg16_type               wrData16   = pwdata[15:0];
    wire logic                    doWrite    = accessDone && pwrite && mapped;

    // Status view: pad levels high byte, routed and assigned pins low byte
    wire logic [PINS_PER_GROUP-1:0] grpPadIn  = padIn[groupIdx*PINS_PER_GROUP +: PINS_PER_GROUP];
    wire logic [PINS_PER_GROUP-1:0] grpActive =
        pinActive[groupIdx*PINS_PER_GROUP +: PINS_PER_GROUP];

    wire reg16_type readData = hitRoute ? routeSet_q[routeIdx]
                             : hitFnc   ? fncSel_q[groupIdx]
                             : hitDir   ? dirEn_q[groupIdx]
                             : hitMode  ? reg16_type'({8'h00, mode_q[groupIdx]})
                             : hitStat  ? reg16_type'({grpPadIn, grpActive})
                             : `RTR_REG_RESET;

    // No wait state: the answer is prepared in setup, offered in access
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setupPhase;
            pslverr_q <= setupPhase && !mapped;
            prdata_q  <= (setupPhase && !pwrite && mapped) ? {16'h0000, readData} : 32'h0000_0000;
        end
    end

    // Route settings, all fields read/write, cleared by reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int r = 0; r < NUM_ROUTES; r++) begin
                routeSet_q[r] <= `RTR_REG_RESET;
            end
        end else if (doWrite && hitRoute) begin
            routeSet_q[routeIdx] <= wrData16;
        end
    end

    // Per-group function, direction and mode registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                fncSel_q[g] <= `RTR_REG_RESET;
                dirEn_q[g]  <= `RTR_REG_RESET;
                mode_q[g]   <= '0;
            end
        end else if (doWrite) begin
            if (hitFnc) fncSel_q[groupIdx] <= wrData16;
            if (hitDir) dirEn_q[groupIdx]  <= wrData16;
            if (hitMode) mode_q[groupIdx]  <= wrData16[PINS_PER_GROUP-1:0];
        end
    end

    // Per pin routing
    genvar p;
    generate
        for (p = 0; p < NUM_PINS; p++) begin : g_pin
            localparam int GRP  = p / PINS_PER_GROUP;
            localparam int BIT  = p % PINS_PER_GROUP;
            localparam int RIDX = p / 2;

            if (BIT % 2 == 0) begin : g_even
                assign pinPer[p] = routeSet_q[RIDX][`RTR_EVEN_PER];
                assign pinCh[p]  = routeSet_q[RIDX][`RTR_EVEN_CH];
                assign pinSig[p] = routeSet_q[RIDX][`RTR_EVEN_SIG];
            end else begin : g_odd
                assign pinPer[p] = routeSet_q[RIDX][`RTR_ODD_PER];
                assign pinCh[p]  = routeSet_q[RIDX][`RTR_ODD_CH];
                assign pinSig[p] = routeSet_q[RIDX][`RTR_ODD_SIG];
            end

            route_decoder u_dec (
                .perChoice (pinPer[p]),
                .chChoice  (pinCh[p]),
                .sigChoice (pinSig[p]),
                .lineValid (pinValid[p]),
                .lineNum   (pinLine[p])
            );

            // Mode bit gates the function choice; choice must be function 1
            assign pinRouted[p] = mode_q[GRP][BIT] &&
                (fncSel_q[GRP][2*BIT +: 2] == `RTR_FNC_PERIPH1);
            assign pinActive[p] = pinRouted[p] && pinValid[p];
            assign pinSelOut[p] = pinValid[p] && periphOut[pinLine[p]];
            assign pinSelOe[p]  = pinValid[p] && periphOe[pinLine[p]] && !inputOnly[pinLine[p]];

            // Unassigned routed pin floats; shared lines fan out identically
            assign padOut_d[p] = pinRouted[p] ? pinSelOut[p] : gpioOut[p];
            assign padOe_d[p]  = pinRouted[p] ? pinSelOe[p]  : gpioOe[p];

            // Sampled reset keeps the release edge out of the check
            fsel_gate_a: assert property (@(posedge core_clk) disable iff (srst)
                !srst && !pinRouted[p] |=> padOe_q[p] == $past(gpioOe[p])
                    && padOut_q[p] == $past(gpioOut[p]))
                else $error("Unrouted pin does not follow GPIO drive");

            hiz_none_a: assert property (@(posedge core_clk) disable iff (srst)
                pinRouted[p] && !pinValid[p] |=> !padOe_q[p])
                else $error("Unassigned routed pin is driven");

            route_pass_a: assert property (@(posedge core_clk) disable iff (srst)
                pinActive[p] |=> padOut_q[p] == $past(pinSelOut[p])
                    && padOe_q[p] == $past(pinSelOe[p]))
                else $error("Routed pin does not carry peripheral drive");

            per_reserved_a: assert property (@(posedge core_clk) disable iff (srst)
                (pinPer[p] > `RTR_PER_TMR || pinPer[p] == `RTR_PER_NONE) |-> !pinValid[p])
                else $error("Reserved peripheral code decoded as valid");

            chan_limit_a: assert property (@(posedge core_clk) disable iff (srst)
                ((pinPer[p] == `RTR_PER_I2C && pinCh[p] > `RTR_I2C_CH_MAX)
                || (pinPer[p] == `RTR_PER_SPI && pinCh[p] > `RTR_SPI_CH_MAX)
                || (pinPer[p] == `RTR_PER_UART && pinCh[p] > `RTR_UART_CH_MAX)
                || (pinPer[p] == `RTR_PER_TMR && pinCh[p] > `RTR_TMR_CH_MAX))
                |-> !pinValid[p])
                else $error("Illegal channel decoded as valid");

            tmr_map_a: assert property (@(posedge core_clk) disable iff (srst)
                pinPer[p] == `RTR_PER_TMR && pinCh[p] == 2'h0 && pinSig[p] == `RTR_SIG_1
                |-> pinValid[p] && pinLine[p] == `RTR_LINE_TMR)
                else $error("Timer output 0 maps to wrong line");

            spi_map_a: assert property (@(posedge core_clk) disable iff (srst)
                pinPer[p] == `RTR_PER_SPI && pinCh[p] == 2'h1 && pinSig[p] == `RTR_SIG_4
                |-> pinValid[p] && pinLine[p] == `RTR_LINE_SPI1_SS)
                else $error("Serial select maps to wrong line");

            // Expected lines come from the code table, not the decoder
            i2c_map_a: assert property (@(posedge core_clk) disable iff (srst)
                pinPer[p] == `RTR_PER_I2C && pinCh[p] == 2'h0 && pinSig[p] == `RTR_SIG_2
                |-> pinValid[p] && pinLine[p] == `RTR_LINE_I2C_SDA)
                else $error("Data line maps wrong");

            uart_map_a: assert property (@(posedge core_clk) disable iff (srst)
                pinPer[p] == `RTR_PER_UART && pinCh[p] == 2'h1 && pinSig[p] == `RTR_SIG_2
                |-> pinValid[p] && pinLine[p] == `RTR_LINE_UART1_TX)
                else $error("Transmit line maps wrong");

            tmr_last_a: assert property (@(posedge core_clk) disable iff (srst)
                pinPer[p] == `RTR_PER_TMR && pinCh[p] == 2'h2 && pinSig[p] == `RTR_SIG_2
                |-> pinValid[p] && pinLine[p] == `RTR_LINE_TMR2_OUT1)
                else $error("Timer output 1 maps wrong");

            sig_reserved_a: assert property (@(posedge core_clk) disable iff (srst)
                (pinSig[p] == 3'h0 || pinSig[p] > `RTR_SIG_4 || (pinPer[p] != `RTR_PER_SPI
                && pinSig[p] > `RTR_SIG_2)) |-> !pinValid[p])
                else $error("Reserved signal decoded as valid");

            in_only_a: assert property (@(posedge core_clk) disable iff (srst)
                pinActive[p] && inputOnly[pinLine[p]] |=> !padOe_q[p])
                else $error("Input line drives a pad");

            // Any pin sharing pin 0's line must match it
            multi_out_a: assert property (@(posedge core_clk) disable iff (srst)
                pinActive[0] && pinActive[p] && pinLine[0] == pinLine[p]
                |=> padOut_q[0] == padOut_q[p] && padOe_q[0] == padOe_q[p])
                else $error("Shared output differs between pins");
        end
    endgenerate

    // Lowest numbered active pin feeds a line; unrouted lines rest idle
    always_comb begin
        periphIn_d = lineIdle;
        for (int l = 0; l < `RTR_NUM_LINES; l++) begin
            for (int q = NUM_PINS - 1; q >= 0; q--) begin
                if (pinActive[q] && (pinLine[q] == line_type'(l))) begin
                    periphIn_d[l] = padIn[q];
                end
            end
        end
    end

    // Pad and peripheral drive registered so outputs come from flops
    always_ff @(posedge core_clk) begin
        if (srst) begin
            padOut_q   <= '0;
            padOe_q    <= '0;
            periphIn_q <= `RTR_LINE_IDLE;
        end else begin
            padOut_q   <= padOut_d;
            padOe_q    <= padOe_d;
            periphIn_q <= periphIn_d;
        end
    end

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign padOut   = padOut_q;
    assign padOe    = padOe_q;
    assign periphIn = periphIn_q;

    group_limit_a: assert property (@(posedge core_clk) disable iff (srst)
        setupPhase && ((paddr & `RTR_MAP_TOP_MASK) != 12'h000) |=> pready_q && pslverr_q)
        else $error("Address beyond group map not refused");

    route_write_a: assert property (@(posedge core_clk) disable iff (srst)
        doWrite && hitRoute |=> routeSet_q[$past(routeIdx)] == $past(wrData16))
        else $error("Route setting write lost");

    // Bus, reset and register checks
    ready_once_a: assert property (@(posedge core_clk) disable iff (srst)
        setupPhase |=> pready_q)
        else $error("Setup not answered");

    ready_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
        pready_q |=> !pready_q)
        else $error("Ready held too long");

    err_ready_a: assert property (@(posedge core_clk) disable iff (srst)
        pslverr_q |-> pready_q)
        else $error("Error without ready");

    err_map_a: assert property (@(posedge core_clk) disable iff (srst)
        setupPhase && mapped |=> !pslverr_q)
        else $error("Mapped access refused");

    unaligned_err_a: assert property (@(posedge core_clk) disable iff (srst)
        setupPhase && ((paddr & `RTR_ALIGN_MASK) != 12'h000) |=> pslverr_q)
        else $error("Unaligned access accepted");

    read_idle_a: assert property (@(posedge core_clk) disable iff (srst)
        !pready_q |-> prdata_q == 32'h0000_0000)
        else $error("Read data outside access");

    route_read_a: assert property (@(posedge core_clk) disable iff (srst)
        setupPhase && !pwrite && hitRoute |=> prdata_q[15:0] == $past(routeSet_q[routeIdx]))
        else $error("Route setting read wrong");

    fnc_write_a: assert property (@(posedge core_clk) disable iff (srst)
        doWrite && hitFnc |=> fncSel_q[$past(groupIdx)] == $past(wrData16))
        else $error("Function choice write lost");

    mode_write_a: assert property (@(posedge core_clk) disable iff (srst)
        doWrite && hitMode |=> mode_q[$past(groupIdx)] == $past(wrData16[PINS_PER_GROUP-1:0]))
        else $error("Mode write lost");

    route_reset_a: assert property (@(posedge core_clk)
        srst |=> routeSet_q[0] == `RTR_REG_RESET && routeSet_q[NUM_ROUTES-1] == `RTR_REG_RESET)
        else $error("Route setting not cleared");

    pad_reset_a: assert property (@(posedge core_clk)
        srst |=> padOe_q == '0 && padOut_q == '0)
        else $error("Pads driven in reset");

    line_idle_a: assert property (@(posedge core_clk)
        srst |=> periphIn_q == `RTR_LINE_IDLE)
        else $error("Lines not idle in reset");
endmodule // port_function_router

// ===== verification/periph_lines_model.sv
// Peripheral-side model: drives the router's line outputs and enables.
// Assumes the bench supplies the wanted line levels on linePattern.
`timescale 1ns/1ps
`include "port_router_defs.svh"

module periph_lines_model
    import port_router_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Wanted line levels
    input  wire logic [19:0] linePattern,
    // Line drive toward the router
    output logic      [19:0] periphOut,
    output logic      [19:0] periphOe
);
    // Registered so that line changes land just after an edge, as in real units
    always_ff @(posedge core_clk) begin
        if (srst) begin
            periphOut <= `RTR_LINE_IDLE;
            periphOe  <= 20'h00000;
        end else begin
            periphOut <= linePattern;
            // Input-only lines have no driver in a real unit
            periphOe  <= ~`RTR_LINE_INPUT_ONLY;
        end
    end
endmodule // periph_lines_model

// ===== verification/universal_port_function_router_bench.sv
// Self-checking bench for the port function router: APB master and pads.
// Assumes the design files and periph_lines_model are compiled first.
`timescale 1ns/1ps
`include "port_router_defs.svh"

module universal_port_function_router_bench
    import port_router_pkg::*;
;
    typedef struct packed {
        logic [1:0] g;
        logic [2:0] pin;
        logic [2:0] per;
        logic [1:0] ch;
        logic [2:0] sig;
        logic       ok;
        logic [4:0] ln;
    } row_type;
    logic        core_clk, srst, psel, penable, pwrite, pready, pslverr, rdErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdData, padIn, padOut, padOe, gpioOut, gpioOe;
    logic [19:0] periphOut, periphOe, periphIn, linePattern, pat, inOnly;
    int          failCount, testsRun, p;
    // Group, pin, peripheral, channel, signal, valid, expected line
    row_type     rows[18] = '{
        '{2'h0, 3'h0, 3'h1, 2'h0, 3'h1, 1'h1, 5'h00}, '{2'h0, 3'h1, 3'h1, 2'h0, 3'h2, 1'h1, 5'h01},
        '{2'h1, 3'h2, 3'h1, 2'h1, 3'h1, 1'h0, 5'h00}, '{2'h1, 3'h3, 3'h2, 2'h0, 3'h1, 1'h1, 5'h02},
        '{2'h2, 3'h4, 3'h2, 2'h1, 3'h4, 1'h1, 5'h09}, '{2'h2, 3'h5, 3'h2, 2'h0, 3'h5, 1'h0, 5'h00},
        '{2'h3, 3'h6, 3'h3, 2'h1, 3'h2, 1'h1, 5'h0D}, '{2'h3, 3'h7, 3'h3, 2'h0, 3'h3, 1'h0, 5'h00},
        '{2'h0, 3'h6, 3'h4, 2'h2, 3'h2, 1'h1, 5'h13}, '{2'h1, 3'h7, 3'h4, 2'h3, 3'h1, 1'h0, 5'h00},
        '{2'h2, 3'h0, 3'h5, 2'h0, 3'h1, 1'h0, 5'h00}, '{2'h3, 3'h1, 3'h0, 2'h0, 3'h1, 1'h0, 5'h00},
        '{2'h0, 3'h3, 3'h2, 2'h1, 3'h3, 1'h1, 5'h08}, '{2'h1, 3'h4, 3'h4, 2'h0, 3'h1, 1'h1, 5'h0E},
        '{2'h2, 3'h7, 3'h7, 2'h0, 3'h1, 1'h0, 5'h00}, '{2'h3, 3'h2, 3'h3, 2'h0, 3'h0, 1'h0, 5'h00},
        '{2'h1, 3'h5, 3'h6, 2'h0, 3'h2, 1'h0, 5'h00}, '{2'h3, 3'h0, 3'h3, 2'h0, 3'h1, 1'h1, 5'h0A}};

    port_function_router i_port_function_router (.core_clk(core_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .periphOut(periphOut), .periphOe(periphOe),
        .periphIn(periphIn));
    periph_lines_model i_periph_lines_model (.core_clk(core_clk), .srst(srst),
        .linePattern(linePattern), .periphOut(periphOut), .periphOe(periphOe));

    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task endTest(input string s);
        $display("Test %s done: %0d checks, %0d mismatches", s, testsRun, failCount);
    endtask

    task completeRun();
        $display("Checks %0d, mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Holds the request until pready is sampled or 16 cycles pass; no latency assumed
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (n >= 16) failCount++;
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    function automatic logic [11:0] routeAddr(input row_type r);
        return {6'h00, r.g, r.pin[2:1], 2'h0};
    endfunction

    function automatic logic [31:0] routeVal(input row_type r);
        return {24'h000000, r.sig, r.ch, r.per} << (r.pin[0] ? 8 : 0);
    endfunction

    task automatic route(input row_type r, input logic [1:0] fnc);
        logic [11:0] off;
        off = {8'h00, r.g, 2'h0};
        apb(1'h1, `RTR_DIR_BASE + off, 32'h0);
        apb(1'h1, `RTR_MODE_BASE + off, 32'h0);
        apb(1'h1, routeAddr(r), routeVal(r));
        apb(1'h1, `RTR_FNC_BASE + off, 32'(fnc) << (2 * r.pin));
        apb(1'h1, `RTR_MODE_BASE + off, 32'h1 << r.pin);
        apb(1'h0, routeAddr(r), 32'h0);
        check(rdData, routeVal(r));
    endtask

    task settle();
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        failCount++;
        completeRun();
    end

    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 47'h0};
        {padIn, gpioOut, gpioOe} = {32'h0F0F55AA, 32'h5A3C96E1, 32'hC3A50F69};
        linePattern = 20'hA5C3E;
        inOnly = `RTR_LINE_INPUT_ONLY;
        repeat (10) @(posedge core_clk);
        check(padOe, 32'h0);
        srst <= 1'h0;
        settle();
        check(padOut, gpioOut);
        check(32'(periphIn), 32'(`RTR_LINE_IDLE));
        endTest("reset");
        foreach (rows[i]) begin
            route(rows[i], `RTR_FNC_PERIPH1);
            p = int'(rows[i].g) * 8 + int'(rows[i].pin);
            for (int v = 0; v < 2; v++) begin
                pat = v ? ~20'hA5C3E : 20'hA5C3E;
                @(posedge core_clk);
                linePattern <= pat;
                padIn <= v ? (32'h1 << p) : ~(32'h1 << p);
                settle();
                if (rows[i].ok) begin
                    check(32'(padOut[p]), 32'(pat[rows[i].ln]));
                    check(32'(padOe[p]), 32'(!inOnly[rows[i].ln]));
                    check(32'(periphIn[rows[i].ln]), 32'(v));
                end else begin
                    check(32'(padOe[p]), 32'h0);
                end
            end
            apb(1'h1, `RTR_FNC_BASE + {8'h00, rows[i].g, 2'h0}, 32'h2 << (2 * rows[i].pin));
            settle();
            check({31'h0, padOut[p]}, {31'h0, gpioOut[p]});
            check({31'h0, padOe[p]}, {31'h0, gpioOe[p]});
            apb(1'h1, `RTR_MODE_BASE + {8'h00, rows[i].g, 2'h0}, 32'h0);
            apb(1'h1, routeAddr(rows[i]), 32'h0);
        end
        endTest("route table");
        apb(1'h0, 12'h080, 32'h0);
        check({rdData[30:0], rdErr}, 32'h1);
        apb(1'h1, 12'h002, 32'hFFFF);
        check({31'h0, rdErr}, 32'h1);
        apb(1'h0, 12'h000, 32'h0);
        check(rdData, 32'h0);
        apb(1'h1, 12'h03C, 32'hFFFFFFFF);
        apb(1'h0, 12'h03C, 32'h0);
        check(rdData, 32'h0000FFFF);
        endTest("register access");
        // One output line on two pins; no input line is shared
        route('{2'h0, 3'h0, 3'h3, 2'h0, 3'h2, 1'h1, 5'h0B}, `RTR_FNC_PERIPH1);
        route('{2'h3, 3'h5, 3'h3, 2'h0, 3'h2, 1'h1, 5'h0B}, `RTR_FNC_PERIPH1);
        for (int v = 0; v < 2; v++) begin
            @(posedge core_clk);
            linePattern <= v ? 20'hFFFFF : 20'h00000;
            settle();
            check({30'h0, padOut[29], padOut[0]}, v ? 32'h3 : 32'h0);
            check({30'h0, padOe[29], padOe[0]}, 32'h3);
        end
        endTest("shared output");
        @(posedge core_clk);
        srst <= 1'h1;
        settle();
        check(padOe, 32'h0);
        check(32'(periphIn), 32'(`RTR_LINE_IDLE));
        @(posedge core_clk);
        srst <= 1'h0;
        apb(1'h0, 12'h03C, 32'h0);
        check(rdData, 32'h0);
        endTest("second reset");
        completeRun();
    end
endmodule // universal_port_function_router_bench
